//--- hw/fwsr_defines.vh
/*
 * Constants for the flash write-status host controller.
 * Assumes a 100 MHz clock and a parallel NOR flash status interface.
 */
`ifndef FWSR_DEFINES_VH
`define FWSR_DEFINES_VH

// Status bit positions in the data byte
`define FWSR_BIT_POLL       7
`define FWSR_BIT_TOGGLE1    6
`define FWSR_BIT_TIMING     5
`define FWSR_BIT_WINDOW     3
`define FWSR_BIT_TOGGLE2    2
`define FWSR_POLL_BIT       7

// Command cycles
`define FWSR_ADDR_UNLOCK1   12'h555
`define FWSR_ADDR_UNLOCK2   12'h2AA
`define FWSR_DATA_UNLOCK1   8'hAA
`define FWSR_DATA_UNLOCK2   8'h55
`define FWSR_DATA_ERASE     8'h80
`define FWSR_DATA_SECTOR    8'h30
`define FWSR_DATA_RESET     8'hF0

// Bus timing, ns and cycles at 10 ns
`define FWSR_CLK_NS         10
`define FWSR_TRC_NS         90
`define FWSR_TRC_CYC        ((`FWSR_TRC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_TWP_NS         45
`define FWSR_TWP_CYC        ((`FWSR_TWP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
// Additional sector commands must come under this spacing
`define FWSR_WIN_US         50
`define FWSR_WIN_CYC        ((`FWSR_WIN_US * 1000) / `FWSR_CLK_NS)

`endif

//--- hw/fwsr_bus_cycle.v
/*
 * One asynchronous flash bus cycle, read or write, with strobe widths
 * stretched to a fixed number of clocks.
 * Assumes the flash data bus is two-way and sampled synchronously.
 */
`timescale 1ns/100ps
`include "fwsr_defines.vh"

module fwsr_bus_cycle #(
	parameter AW  = 12,
	parameter CYC = `FWSR_TRC_CYC
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          rst_n_i,
	// Request
	input  wire          start_i,
	input  wire          write_i,
	input  wire [AW-1:0] addr_i,
	input  wire [7:0]    wdata_i,
	output reg           done_o,
	output reg  [7:0]    rdata_o,
	// Flash pins
	output reg  [AW-1:0] fl_addr_o,
	output reg           fl_ce_n_o,
	output reg           fl_oe_n_o,
	output reg           fl_we_n_o,
	input  wire [7:0]    fl_dq_i,
	output reg  [7:0]    fl_dq_o,
	output reg           fl_dq_oe_o
);
	reg [7:0] cnt_ff;
	reg       busy_ff;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff     <= 8'h00;
			busy_ff    <= 1'b0;
			done_o     <= 1'b0;
			rdata_o    <= 8'h00;
			fl_addr_o  <= {AW{1'b0}};
			fl_ce_n_o  <= 1'b1;
			fl_oe_n_o  <= 1'b1;
			fl_we_n_o  <= 1'b1;
			fl_dq_o    <= 8'h00;
			fl_dq_oe_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy_ff && start_i) begin
				busy_ff    <= 1'b1;
				cnt_ff     <= CYC[7:0];
				fl_addr_o  <= addr_i;
				fl_ce_n_o  <= 1'b0;
				fl_oe_n_o  <= write_i;
				fl_we_n_o  <= !write_i;
				fl_dq_o    <= wdata_i;
				fl_dq_oe_o <= write_i;
			end else if (busy_ff) begin
				if (cnt_ff == 8'h01) begin
					busy_ff    <= 1'b0;
					done_o     <= 1'b1;
					rdata_o    <= fl_dq_i;
					fl_ce_n_o  <= 1'b1;
					fl_oe_n_o  <= 1'b1;
					fl_we_n_o  <= 1'b1;
					fl_dq_oe_o <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff - 8'h01;
				end
			end
		end
	end
endmodule

//--- hw/fwsr_host.v
/*
 * Host controller that erases sectors, and appends added sectors, on a parallel
 * NOR flash and tracks completion through the status bits.
 * Assumes the flash keeps its own status rules; inputs are synchronous.
 */
`timescale 1ns/100ps
`include "fwsr_defines.vh"

module fwsr_host #(
	parameter AW      = 12,
	parameter WIN_CYC = `FWSR_WIN_CYC
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          rst_n_i,
	// User orders
	input  wire          erase_i,
	input  wire [AW-1:0] sector_i,
	input  wire          more_i,
	output reg           busy_o,
	output reg           done_o,
	output reg           fail_o,
	output reg           rejected_o,
	// Flash pins
	output wire [AW-1:0] fl_addr_o,
	output wire          fl_ce_n_o,
	output wire          fl_oe_n_o,
	output wire          fl_we_n_o,
	input  wire [7:0]    fl_dq_i,
	output wire [7:0]    fl_dq_o,
	output wire          fl_dq_oe_o,
	input  wire          fl_ready_i
);
	localparam [7:0] S_IDLE = 8'h01;
	localparam [7:0] S_CMD  = 8'h02;
	localparam [7:0] S_RD1  = 8'h04;
	localparam [7:0] S_RD2  = 8'h08;
	localparam [7:0] S_WCHK = 8'h10;
	localparam [7:0] S_RCHK = 8'h20;
	localparam [7:0] S_RST  = 8'h40;
	localparam [7:0] S_WAIT = 8'h80;

	reg [7:0]    state_ff;
	reg [2:0]    step_ff;
	reg [2:0]    last_ff;
	reg          go_ff;
	reg          wr_ff;
	reg [AW-1:0] a_ff;
	reg [7:0]    d_ff;
	reg [AW-1:0] sec_ff;
	reg          first_ff;
	reg          recheck_ff;
	reg          prewin_ff;
	reg          pend_ff;
	reg [AW-1:0] pend_sec_ff;
	reg [15:0]   gap_ff;
	wire         cyc_done;
	wire [7:0]   rd;

	// Command cycle table: six writes for erase, one for reset
	function [AW+7:0] cmd_word;
		input [2:0]    idx;
		input [AW-1:0] sec;
		begin
			case (idx)
			3'd0:    cmd_word = {`FWSR_ADDR_UNLOCK1, `FWSR_DATA_UNLOCK1};
			3'd1:    cmd_word = {`FWSR_ADDR_UNLOCK2, `FWSR_DATA_UNLOCK2};
			3'd2:    cmd_word = {`FWSR_ADDR_UNLOCK1, `FWSR_DATA_ERASE};
			3'd3:    cmd_word = {`FWSR_ADDR_UNLOCK1, `FWSR_DATA_UNLOCK1};
			3'd4:    cmd_word = {`FWSR_ADDR_UNLOCK2, `FWSR_DATA_UNLOCK2};
			3'd5:    cmd_word = {sec, `FWSR_DATA_SECTOR};
			default: cmd_word = {sec, `FWSR_DATA_RESET};
			endcase
		end
	endfunction

	fwsr_bus_cycle #(.AW(AW)) u_cyc (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.start_i    (go_ff),
		.write_i    (wr_ff),
		.addr_i     (a_ff),
		.wdata_i    (d_ff),
		.done_o     (cyc_done),
		.rdata_o    (rd),
		.fl_addr_o  (fl_addr_o),
		.fl_ce_n_o  (fl_ce_n_o),
		.fl_oe_n_o  (fl_oe_n_o),
		.fl_we_n_o  (fl_we_n_o),
		.fl_dq_i    (fl_dq_i),
		.fl_dq_o    (fl_dq_o),
		.fl_dq_oe_o (fl_dq_oe_o)
	);

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff    <= S_IDLE;
			step_ff     <= 3'd0;
			last_ff     <= 3'd0;
			go_ff       <= 1'b0;
			wr_ff       <= 1'b0;
			a_ff        <= {AW{1'b0}};
			d_ff        <= 8'h00;
			sec_ff      <= {AW{1'b0}};
			first_ff    <= 1'b0;
			recheck_ff  <= 1'b0;
			prewin_ff   <= 1'b0;
			pend_ff     <= 1'b0;
			pend_sec_ff <= {AW{1'b0}};
			gap_ff      <= 16'h0000;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			fail_o      <= 1'b0;
			rejected_o  <= 1'b0;
		end else begin
			go_ff      <= 1'b0;
			done_o     <= 1'b0;
			rejected_o <= 1'b0;
			if (gap_ff != 16'h0000)
				gap_ff <= gap_ff - 16'h0001;
			if (more_i && busy_o && !pend_ff) begin
				pend_ff     <= 1'b1;
				pend_sec_ff <= sector_i;
			end
			case (state_ff)
			S_IDLE: begin
				if (erase_i) begin
					busy_o   <= 1'b1;
					fail_o   <= 1'b0;
					sec_ff   <= sector_i;
					step_ff  <= 3'd0;
					last_ff  <= 3'd5;
					{a_ff, d_ff} <= cmd_word(3'd0, sector_i);
					wr_ff    <= 1'b1;
					go_ff    <= 1'b1;
					state_ff <= S_CMD;
				end
			end
			S_CMD: begin
				if (cyc_done) begin
					if (step_ff == last_ff) begin
						// Status reads always at the erased sector
						a_ff     <= sec_ff;
						wr_ff    <= 1'b0;
						go_ff    <= 1'b1;
						gap_ff   <= WIN_CYC[15:0];
						state_ff <= (last_ff == 3'd6) ? S_WAIT : S_RD1;
					end else begin
						step_ff <= step_ff + 3'd1;
						{a_ff, d_ff} <= cmd_word(step_ff + 3'd1, sec_ff);
						go_ff   <= 1'b1;
					end
				end
			end
			S_RD1: begin
				if (cyc_done) begin
					first_ff <= rd[`FWSR_BIT_TOGGLE1];
					go_ff    <= 1'b1;
					state_ff <= S_RD2;
				end
			end
			S_RD2: begin
				if (cyc_done) begin
					if (rd[`FWSR_BIT_TOGGLE1] == first_ff) begin
						recheck_ff <= 1'b0;
						pend_ff    <= 1'b0;
						busy_o     <= 1'b0;
						done_o     <= 1'b1;
						state_ff   <= S_IDLE;
					end else if (recheck_ff) begin
						// Still toggling after the flag rose: failed
						fail_o   <= 1'b1;
						step_ff  <= 3'd6;
						last_ff  <= 3'd6;
						{a_ff, d_ff} <= cmd_word(3'd6, sec_ff);
						wr_ff    <= 1'b1;
						go_ff    <= 1'b1;
						state_ff <= S_CMD;
					end else if (rd[`FWSR_BIT_TIMING]) begin
						recheck_ff <= 1'b1;
						go_ff      <= 1'b1;
						state_ff   <= S_RD1;
					end else if (pend_ff) begin
						// Window read before the added command
						go_ff    <= 1'b1;
						state_ff <= S_WCHK;
					end else begin
						go_ff    <= 1'b1;
						state_ff <= S_RD1;
					end
				end
			end
			S_WCHK: begin
				if (cyc_done) begin
					pend_ff <= 1'b0;
					if (rd[`FWSR_BIT_WINDOW]) begin
						rejected_o <= 1'b1;
						go_ff      <= 1'b1;
						state_ff   <= S_RD1;
					end else begin
						// Window open: append the sector
						prewin_ff <= 1'b0;
						sec_ff    <= pend_sec_ff;
						step_ff   <= 3'd0;
						last_ff   <= 3'd5;
						{a_ff, d_ff} <= cmd_word(3'd0, pend_sec_ff);
						wr_ff     <= 1'b1;
						go_ff     <= 1'b1;
						state_ff  <= S_RCHK;
					end
				end
			end
			S_RCHK: begin
				// Send the added sequence, then read the window again
				if (cyc_done) begin
					if (prewin_ff) begin
						if (rd[`FWSR_BIT_WINDOW] && gap_ff == 16'h0000)
							rejected_o <= 1'b1;
						go_ff    <= 1'b1;
						state_ff <= S_RD1;
					end else if (step_ff == last_ff) begin
						prewin_ff <= 1'b1;
						a_ff      <= sec_ff;
						wr_ff     <= 1'b0;
						go_ff     <= 1'b1;
					end else begin
						step_ff <= step_ff + 3'd1;
						{a_ff, d_ff} <= cmd_word(step_ff + 3'd1, sec_ff);
						go_ff   <= 1'b1;
					end
				end
			end
			S_WAIT: begin
				// Reset read cycle done and device ready again
				// Never leave with a bus cycle still running
				if (cyc_done) begin
					if (fl_ready_i) begin
						busy_o     <= 1'b0;
						done_o     <= 1'b1;
						recheck_ff <= 1'b0;
						pend_ff    <= 1'b0;
						state_ff   <= S_IDLE;
					end else begin
						go_ff <= 1'b1;
					end
				end
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

//--- testbench/fwsr_host_assertions.sv
/* Port assertions for the flash status host.
   Assumes one clock domain, bound onto fwsr_host. */
`timescale 1ns/100ps
module fwsr_host_chk #(
	parameter AW = 12
) (
	input wire          clk_i,
	input wire          rst_n_i,
	input wire          erase_i,
	input wire [AW-1:0] sector_i,
	input wire          more_i,
	input wire          busy_o,
	input wire          done_o,
	input wire          fail_o,
	input wire          rejected_o,
	input wire [AW-1:0] fl_addr_o,
	input wire          fl_ce_n_o,
	input wire          fl_oe_n_o,
	input wire          fl_we_n_o,
	input wire [7:0]    fl_dq_o,
	input wire          fl_dq_oe_o
);
	reg [AW-1:0] sec_a_ff;
	reg [AW-1:0] sec_b_ff;
	reg          f0_ff;
	reg          oe_q_ff;
	reg [1:0]    rd_ff;
	// Sectors in play, reset command seen, reads since start
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sec_a_ff <= {AW{1'b0}};
			sec_b_ff <= {AW{1'b0}};
			f0_ff <= 1'b0;
			oe_q_ff <= 1'b1;
			rd_ff <= 2'h0;
		end else begin
			oe_q_ff <= fl_oe_n_o;
			if (erase_i && !busy_o) begin
				sec_a_ff <= sector_i;
				sec_b_ff <= sector_i;
				f0_ff <= 1'b0;
				rd_ff <= 2'h0;
			end else begin
				if (more_i && busy_o)
					sec_b_ff <= sector_i;
				if (!fl_we_n_o && fl_dq_o == 8'hF0)
					f0_ff <= 1'b1;
				if (!fl_oe_n_o && oe_q_ff && rd_ff != 2'h3)
					rd_ff <= rd_ff + 2'h1;
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_TAKE: assert property (erase_i && !busy_o |=> busy_o)
		else $error("busy not raised");
	AST_DONE_ONE: assert property (done_o |=> !done_o)
		else $error("done longer than a cycle");
	AST_SHAPE: assert property ($fell(fl_ce_n_o) |->
		##1 (!fl_ce_n_o)[*8] ##1 fl_ce_n_o) else $error("bad cycle");
	AST_HOLD: assert property (!fl_ce_n_o ##1 !fl_ce_n_o |->
		$stable(fl_addr_o) && $stable(fl_dq_oe_o)) else $error("moved");
	AST_CLASH: assert property (fl_we_n_o || fl_oe_n_o)
		else $error("read and write together");
	AST_DRIVE: assert property (!fl_oe_n_o |-> !fl_dq_oe_o)
		else $error("drive during read");
	AST_ADDR: assert property (!fl_oe_n_o && !f0_ff |->
		fl_addr_o == sec_a_ff || fl_addr_o == sec_b_ff)
		else $error("status read off sector");
	AST_RST_CMD: assert property (done_o && fail_o |-> f0_ff)
		else $error("no reset command");
	AST_TWO_READS: assert property (done_o |-> rd_ff >= 2'h2)
		else $error("done on one read");
	AST_RECHECK: assert property (done_o && fail_o |-> rd_ff == 2'h3)
		else $error("fail without recheck");
	COV_OK: cover property (done_o && !fail_o);
	COV_FAIL: cover property (done_o && fail_o);
	COV_REJ: cover property (rejected_o);
endmodule
bind fwsr_host fwsr_host_chk #(.AW(AW)) fwsr_host_chk_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .erase_i(erase_i),
	.sector_i(sector_i), .more_i(more_i), .busy_o(busy_o),
	.done_o(done_o), .fail_o(fail_o), .rejected_o(rejected_o),
	.fl_addr_o(fl_addr_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o),
	.fl_we_n_o(fl_we_n_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o)
);

//--- testbench/fwsr_flash_model.sv
/* Behavioural NOR flash, sector erase status only.
   Assumes host strobes change on clk_i edges. */
`timescale 1ns/100ps
module fwsr_flash_model #(
	parameter AW = 12
) (
	input  wire          clk_i,
	input  wire          rst_n_i,
	input  wire [AW-1:0] addr_i,
	input  wire          ce_n_i,
	input  wire          oe_n_i,
	input  wire          we_n_i,
	input  wire [7:0]    dq_i,
	input  wire          fail_i,
	input  wire [7:0]    win_i,
	input  wire [3:0]    len_i,
	output wire [7:0]    q_o,
	output wire          ry_o,
	output reg  [1:0]    nsec_o
);
	reg        busy_ff, tog_ff, tog2_ff, lim_ff, oe_q_ff, we_q_ff, susp_ff;
	reg [7:0]  win_ff, last_ff;
	reg [3:0]  left_ff;
	wire       shut = (win_ff == 8'h00);
	wire       drv = !ce_n_i && !oe_n_i;
	// Suspended status: polling 1, steady toggle, timing flag 0
	wire [7:0] stat = susp_ff ?
		{1'b1, tog_ff, 1'b0, 2'b00, tog2_ff, 2'b00} :
		{1'b0, tog_ff, lim_ff, 1'b0, shut, tog2_ff, 2'b00};
	// Released bus shows the inverse of the last value
	assign q_o = drv ? (busy_ff ? stat : 8'hFF) : ~last_ff;
	assign ry_o = !busy_ff || susp_ff;
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{busy_ff, tog_ff, tog2_ff, lim_ff, susp_ff} <= 5'h00;
			{oe_q_ff, we_q_ff} <= 2'h3;
			win_ff <= 8'h00;
			last_ff <= 8'h00;
			left_ff <= 4'h0;
			nsec_o <= 2'h0;
		end else begin
			oe_q_ff <= oe_n_i;
			we_q_ff <= we_n_i;
			if (drv)
				last_ff <= q_o;
			if (!shut)
				win_ff <= win_ff - 8'h01;
			if (!we_n_i && we_q_ff && !ce_n_i) begin
				// Only the sector erase byte arms the window
				if (dq_i == 8'h30 && !busy_ff) begin
					busy_ff <= 1'b1;
					nsec_o <= 2'h1;
					win_ff <= win_i;
					left_ff <= len_i;
				end else if (dq_i == 8'h30 && !shut) begin
					nsec_o <= nsec_o + 2'h1;
					win_ff <= win_i;
				end else if (dq_i == 8'h30 && susp_ff) begin
					susp_ff <= 1'b0;
				end else if (dq_i == 8'hF0 && lim_ff) begin
					{busy_ff, lim_ff} <= 2'h0;
				end else if (dq_i == 8'hB0 && busy_ff && shut) begin
					susp_ff <= 1'b1;
				end
			end
			if (oe_n_i && !oe_q_ff && busy_ff) begin
				tog2_ff <= !tog2_ff;
				if (!susp_ff) begin
					tog_ff <= !tog_ff;
					if (shut && left_ff != 4'h0)
						left_ff <= left_ff - 4'h1;
					// fail_i stands for a 0-to-1 program that cannot finish
					else if (shut && fail_i)
						lim_ff <= 1'b1;
					else if (shut)
						busy_ff <= 1'b0;
				end
			end
		end
	end
endmodule

//--- testbench/fwsr_host_bench.sv
/* Self-checking bench for the flash status host.
   Assumes the flash model and the bound checker. */
`timescale 1ns/100ps
`define CHK(a, b) begin \
	compares = compares + 1; \
	if ((a) !== (b)) begin \
		mismatches = mismatches + 1; \
		$display("Error at %0t: got %h expected %h", $time, a, b); \
	end \
end
module fwsr_host_bench;
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg         erase_i = 1'b0;
	reg  [11:0] sector_i = 12'h000;
	reg         more_i = 1'b0;
	reg         fail = 1'b0;
	reg  [7:0]  win = 8'h04;
	reg  [3:0]  len = 4'h2;
	wire        busy_o, done_o, fail_o, rejected_o, ce_n, oe_n, we_n;
	wire        dq_oe, ry;
	wire [11:0] addr;
	wire [7:0]  dq_o, q, dq_i;
	wire [1:0]  nsec;
	integer     mismatches = 0;
	integer     compares = 0;
	integer     rej, i, n, r;
	assign dq_i = dq_oe ? dq_o : q;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (rejected_o === 1'b1)
			rej = rej + 1;
	end
	fwsr_host #(.AW(12), .WIN_CYC(20)) fwsr_host_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .erase_i(erase_i),
		.sector_i(sector_i), .more_i(more_i), .busy_o(busy_o),
		.done_o(done_o), .fail_o(fail_o), .rejected_o(rejected_o),
		.fl_addr_o(addr), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n),
		.fl_we_n_o(we_n), .fl_dq_i(dq_i), .fl_dq_o(dq_o),
		.fl_dq_oe_o(dq_oe), .fl_ready_i(ry)
	);
	fwsr_flash_model #(.AW(12)) fwsr_flash_model_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_o), .fail_i(fail),
		.win_i(win), .len_i(len), .q_o(q), .ry_o(ry), .nsec_o(nsec)
	);
	task final_report;
		begin
			$display("Mismatches %0d, compares %0d", mismatches, compares);
			if (mismatches == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// One erase, optionally one added sector, then status checks
	task op(input f, input [7:0] w, input m);
		begin
			rej = 0;
			@(posedge clk_i);
			fail <= f;
			win <= w;
			len <= m ? 4'hC : 4'($urandom_range(9, 2));
			sector_i <= 12'($urandom);
			erase_i <= 1'b1;
			@(posedge clk_i);
			erase_i <= 1'b0;
			if (m) begin
				repeat (30) @(posedge clk_i);
				sector_i <= sector_i + 12'h001;
				more_i <= 1'b1;
				@(posedge clk_i);
				more_i <= 1'b0;
			end
			for (n = 0; n < 20000 && done_o !== 1'b1; n = n + 1) begin
				@(posedge clk_i);
				#1;
			end
			if (n == 20000) begin
				mismatches = mismatches + 1;
				final_report;
			end else begin
				`CHK(fail_o, f)
				`CHK(busy_o, 1'b0)
				`CHK(nsec, (m && w > 8'h40) ? 2'h2 : 2'h1)
				`CHK(rej > 0, m && w < 8'h40)
			end
		end
	endtask
	initial begin
		r = $urandom(80);
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		op(1'b0, 8'h04, 1'b0);
		op(1'b1, 8'h04, 1'b0);
		op(1'b0, 8'hFF, 1'b1);
		op(1'b0, 8'h01, 1'b1);
		for (i = 0; i < 6; i = i + 1)
			op(1'($urandom), 8'($urandom_range(60, 1)), 1'b0);
		final_report;
	end
endmodule
